// ===== design/rre_exec.sv
// Purpose: Execute stage for the return and rotate-through-carry instructions.
// Assumes: Decode offers a word with instr_valid; file read data and carry
//          arrive combinationally on the same clock for the offered word.
// Notes:   All effects appear as one-cycle pulses the cycle after the word is
//          taken. Words of other instructions are taken and ignored here.
`timescale 1ns/100ps
`include "rre_cfg.svh"

module rre_exec (
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  // Decode side.
  input  wire logic                     instr_valid,
  input  wire logic [`RRE_INSTR_W-1:0]  instr_word,
  output logic                          instr_ready,
  // Return stack.
  input  wire logic [`RRE_PC_W-1:0]     stack_top_value,
  output logic                          stack_pop,
  // Program counter and fetch.
  output logic                          pc_load,
  output logic      [`RRE_PC_W-1:0]     pc_load_value,
  output logic                          fetch_flush,
  // Working register.
  output logic                          w_we,
  output logic      [`RRE_DATA_W-1:0]   w_data,
  // File registers.
  output logic      [`RRE_FADDR_W-1:0]  file_rd_addr,
  input  wire logic [`RRE_DATA_W-1:0]   file_rd_data,
  output logic                          file_we,
  output logic      [`RRE_FADDR_W-1:0]  file_wr_addr,
  output logic      [`RRE_DATA_W-1:0]   file_wr_data,
  // Status carry.
  input  wire logic                     carry_in,
  output logic                          carry_we,
  output logic                          carry_data,
  // Interrupt control register, bit set.
  output logic                          interrupt_control_reg_set,
  output logic      [`RRE_DATA_W-1:0]   interrupt_control_reg_mask
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  rre_pkg::rre_state_e              state;
  rre_pkg::rre_state_e              next_state;
  rre_pkg::rre_op_e                 op;
  logic                             take;
  logic                             dest_file;
  logic [`RRE_DATA_W-1:0]           rot_result;
  logic                             rot_carry;
  logic                             rot_left;

  // The flush cycle refuses a new word: that word was fetched behind the
  // return and is thrown away, so the second cycle is a no-operation.
  assign instr_ready = (state == rre_pkg::RRE_ST_EXEC);
  assign take        = instr_valid && instr_ready;

  // The five patterns are disjoint, so the order of the tests is free; words
  // outside all of them decode to no operation and are taken without effect.
  always_comb begin
    op = rre_pkg::RRE_OP_NONE;
    if ((instr_word & `RRE_RET_MASK) == `RRE_RET_MATCH) begin
      op = rre_pkg::RRE_OP_RET;
    end else if ((instr_word & `RRE_RET_IRQ_MASK) == `RRE_RET_IRQ_MATCH) begin
      op = rre_pkg::RRE_OP_RET_IRQ;
    end else if ((instr_word & `RRE_RET_LIT_MASK) == `RRE_RET_LIT_MATCH) begin
      op = rre_pkg::RRE_OP_RET_LIT;
    end else if ((instr_word & `RRE_ROT_LEFT_MASK) == `RRE_ROT_LEFT_MATCH) begin
      op = rre_pkg::RRE_OP_ROT_LEFT;
    end else if ((instr_word & `RRE_ROT_RIGHT_MASK) == `RRE_ROT_RIGHT_MATCH) begin
      op = rre_pkg::RRE_OP_ROT_RIGHT;
    end
  end

  // Only the low seven bits address the file, giving the range 0 to 127.
  assign file_rd_addr = instr_word[`RRE_FADDR_LSB +: `RRE_FADDR_W];
  assign dest_file    = instr_word[`RRE_DEST_BIT];

  // One datapath serves both rotates; only the left opcode turns it left.
  assign rot_left     = (op == rre_pkg::RRE_OP_ROT_LEFT);

  ////////////////////////////////////////////////////////////////////////////
  // Rotate datapath.

  rre_rotate u_rotate (
    .rotate_left (rot_left),
    .operand     (file_rd_data),
    .carry_in    (carry_in),
    .result      (rot_result),
    .carry_out   (rot_carry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next values.

  logic                             next_stack_pop;
  logic                             next_pc_load;
  logic [`RRE_PC_W-1:0]             next_pc_load_value;
  logic                             next_fetch_flush;
  logic                             next_w_we;
  logic [`RRE_DATA_W-1:0]           next_w_data;
  logic                             next_file_we;
  logic [`RRE_FADDR_W-1:0]          next_file_wr_addr;
  logic [`RRE_DATA_W-1:0]           next_file_wr_data;
  logic                             next_carry_we;
  logic                             next_carry_data;
  logic                             next_icr_set;
  logic [`RRE_DATA_W-1:0]           next_icr_mask;

  // Data fields hold their last value between pulses; only the strobes
  // return to zero, so a consumer must qualify data with its strobe.
  always_comb begin
    next_state         = state;
    next_stack_pop     = 1'b0;
    next_pc_load       = 1'b0;
    next_pc_load_value = pc_load_value;
    next_fetch_flush   = 1'b0;
    next_w_we          = 1'b0;
    next_w_data        = w_data;
    next_file_we       = 1'b0;
    next_file_wr_addr  = file_wr_addr;
    next_file_wr_data  = file_wr_data;
    next_carry_we      = 1'b0;
    next_carry_data    = carry_data;
    next_icr_set       = 1'b0;
    // The set touches only the enable bit; the register owner ORs it in.
    next_icr_mask      = `RRE_IRQ_EN_MASK;
    unique case (state)
      rre_pkg::RRE_ST_EXEC: begin
        if (take) begin
          unique case (op)
            rre_pkg::RRE_OP_RET,
            rre_pkg::RRE_OP_RET_IRQ,
            rre_pkg::RRE_OP_RET_LIT: begin
              // Every return pops and redirects; status is never touched.
              next_stack_pop     = 1'b1;
              next_pc_load       = 1'b1;
              next_pc_load_value = stack_top_value;
              next_fetch_flush   = 1'b1;
              next_state         = rre_pkg::RRE_ST_FLUSH;
              if (op == rre_pkg::RRE_OP_RET_IRQ) begin
                next_icr_set = 1'b1;
              end
              if (op == rre_pkg::RRE_OP_RET_LIT) begin
                next_w_we   = 1'b1;
                next_w_data = instr_word[`RRE_LIT_LSB +: `RRE_DATA_W];
              end
            end
            rre_pkg::RRE_OP_ROT_LEFT,
            rre_pkg::RRE_OP_ROT_RIGHT: begin
              // Carry and operand are read for this word only; a rotate of either direction
              // behind another needs forwarding outside this stage.
              next_carry_we   = 1'b1;
              next_carry_data = rot_carry;
              if (dest_file) begin
                next_file_we      = 1'b1;
                next_file_wr_addr = file_rd_addr;
                next_file_wr_data = rot_result;
              end else begin
                next_w_we   = 1'b1;
                next_w_data = rot_result;
              end
            end
            rre_pkg::RRE_OP_NONE: begin
              next_state = rre_pkg::RRE_ST_EXEC;
            end
            default: begin
              next_state = rre_pkg::RRE_ST_EXEC;
            end
          endcase
        end
      end
      rre_pkg::RRE_ST_FLUSH: begin
        // Second cycle of a return: nothing executes while fetch restarts.
        // The word offered now is the stale one behind the return and is refused.
        next_state = rre_pkg::RRE_ST_EXEC;
      end
      default: begin
        next_state = rre_pkg::RRE_ST_EXEC;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // Reset leaves the stage ready, so decode may offer a word at the first edge
  // after release. Strobes are registered so every effect lands one edge later.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state                     <= rre_pkg::RRE_ST_EXEC;
      stack_pop                 <= 1'b0;
      pc_load                   <= 1'b0;
      pc_load_value             <= `RRE_PC_RST;
      fetch_flush               <= 1'b0;
      w_we                      <= 1'b0;
      w_data                    <= `RRE_DATA_RST;
      file_we                   <= 1'b0;
      file_wr_addr              <= `RRE_FADDR_RST;
      file_wr_data              <= `RRE_DATA_RST;
      carry_we                  <= 1'b0;
      carry_data                <= 1'b0;
      interrupt_control_reg_set <= 1'b0;
      interrupt_control_reg_mask <= `RRE_IRQ_EN_MASK;
    end else begin
      state                     <= next_state;
      stack_pop                 <= next_stack_pop;
      pc_load                   <= next_pc_load;
      pc_load_value             <= next_pc_load_value;
      fetch_flush               <= next_fetch_flush;
      w_we                      <= next_w_we;
      w_data                    <= next_w_data;
      file_we                   <= next_file_we;
      file_wr_addr              <= next_file_wr_addr;
      file_wr_data              <= next_file_wr_data;
      carry_we                  <= next_carry_we;
      carry_data                <= next_carry_data;
      interrupt_control_reg_set <= next_icr_set;
      interrupt_control_reg_mask <= next_icr_mask;
    end
  end

endmodule : rre_exec

// ===== design/rre_cfg.svh
// Purpose: Constants for the return and rotate execution logic of the core.
// Assumes: 16-bit instruction words, 15-bit program counter, 8-bit data path.
// Notes:   Offsets, field positions, opcodes and cycle counts live here only.
`ifndef RRE_CFG_SVH
`define RRE_CFG_SVH

`define RRE_INSTR_W        16
`define RRE_PC_W           15
`define RRE_DATA_W         8
`define RRE_FADDR_W        7

// Opcode matching: a word is a given instruction when (word & mask) == match.
`define RRE_RET_MASK       16'hFFFE
`define RRE_RET_MATCH      16'h0012
`define RRE_RET_IRQ_MASK     16'hFFFE
`define RRE_RET_IRQ_MATCH    16'h0010
`define RRE_RET_LIT_MASK     16'hFF00
`define RRE_RET_LIT_MATCH    16'h0C00
`define RRE_ROT_LEFT_MASK    16'hFC00
`define RRE_ROT_LEFT_MATCH   16'h3400
`define RRE_ROT_RIGHT_MASK   16'hFC00
`define RRE_ROT_RIGHT_MATCH  16'h3000

// Field positions inside the instruction word.
`define RRE_DEST_BIT       9
`define RRE_FADDR_LSB      0
`define RRE_LIT_LSB        0

// Interrupt control register: the global enable sits in bit 7.
`define RRE_IRQ_EN_BIT     7
`define RRE_IRQ_EN_MASK    8'h80

// Cycle counts of the executed instructions.
`define RRE_RET_CYCLES     2
`define RRE_ROT_CYCLES     1

// Reset values.
`define RRE_PC_RST         15'h0000
`define RRE_DATA_RST       8'h00
`define RRE_FADDR_RST      7'h00

`endif

// ===== design/rre_pkg.sv
// Purpose: Types shared by the return and rotate execution logic.
// Assumes: Constants come from rre_cfg.svh.
// Notes:   Only types live here.
package rre_pkg;

  // Execution state, one-hot.
  typedef enum logic [1:0] {
    RRE_ST_EXEC  = 2'b01,
    RRE_ST_FLUSH = 2'b10
  } rre_state_e;

  // Decoded operation class.
  typedef enum logic [2:0] {
    RRE_OP_NONE   = 3'h0,
    RRE_OP_RET    = 3'h1,
    RRE_OP_RET_IRQ   = 3'h2,
    RRE_OP_RET_LIT   = 3'h3,
    RRE_OP_ROT_LEFT  = 3'h4,
    RRE_OP_ROT_RIGHT = 3'h5
  } rre_op_e;

endpackage : rre_pkg

// ===== design/rre_rotate.sv
// Purpose: One-bit rotate of a byte through the carry flag.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   Direction is chosen per call, so one instance serves both rotates.
`timescale 1ns/100ps
`include "rre_cfg.svh"

module rre_rotate (
  input  wire logic                    rotate_left,
  input  wire logic [`RRE_DATA_W-1:0]  operand,
  input  wire logic                    carry_in,
  output logic      [`RRE_DATA_W-1:0]  result,
  output logic                         carry_out
);

  always_comb begin
    if (rotate_left) begin
      result    = {operand[`RRE_DATA_W-2:0], carry_in};
      carry_out = operand[`RRE_DATA_W-1];
    end else begin
      result    = {carry_in, operand[`RRE_DATA_W-1:1]};
      carry_out = operand[0];
    end
  end

endmodule : rre_rotate

// ===== sim/rre_exec_sva.sv
// Purpose: Concurrent checks on the return and rotate execute stage.
// Assumes: Effects pulse exactly one cycle after the edge that takes a word.
// Notes:   Bound to every rre_exec instance at the foot of this file.
`timescale 1ns/100ps
`include "rre_cfg.svh"

module rre_exec_sva (
  input wire logic                     core_clk,
  input wire logic                     rst_b,
  input wire logic                     instr_valid,
  input wire logic [`RRE_INSTR_W-1:0]  instr_word,
  input wire logic                     instr_ready,
  input wire logic [`RRE_PC_W-1:0]     stack_top_value,
  input wire logic                     stack_pop,
  input wire logic                     pc_load,
  input wire logic [`RRE_PC_W-1:0]     pc_load_value,
  input wire logic                     fetch_flush,
  input wire logic                     w_we,
  input wire logic [`RRE_DATA_W-1:0]   w_data,
  input wire logic [`RRE_FADDR_W-1:0]  file_rd_addr,
  input wire logic [`RRE_DATA_W-1:0]   file_rd_data,
  input wire logic                     file_we,
  input wire logic [`RRE_FADDR_W-1:0]  file_wr_addr,
  input wire logic [`RRE_DATA_W-1:0]   file_wr_data,
  input wire logic                     carry_in,
  input wire logic                     carry_we,
  input wire logic                     carry_data,
  input wire logic                     interrupt_control_reg_set,
  input wire logic [`RRE_DATA_W-1:0]   interrupt_control_reg_mask
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  wire       take   = instr_valid && instr_ready;
  wire       is_irq = (instr_word & `RRE_RET_IRQ_MASK) == `RRE_RET_IRQ_MATCH;
  wire       is_lit = (instr_word & `RRE_RET_LIT_MASK) == `RRE_RET_LIT_MATCH;
  wire       is_ret = is_irq || is_lit || ((instr_word & `RRE_RET_MASK) == `RRE_RET_MATCH);
  wire       is_rl  = (instr_word & `RRE_ROT_LEFT_MASK) == `RRE_ROT_LEFT_MATCH;
  wire       is_rr  = (instr_word & `RRE_ROT_RIGHT_MASK) == `RRE_ROT_RIGHT_MATCH;
  wire [7:0] rl_res = {file_rd_data[6:0], carry_in};
  wire [7:0] rr_res = {carry_in, file_rd_data[7:1]};
  wire [7:0] dst    = file_we ? file_wr_data : w_data;

  ////////////////////////////////////////////////////////////////////////////////
  // A return leaves one dead cycle for the refetch, then accepts again.
  sequence s_flush;
    !instr_ready ##1 instr_ready;
  endsequence

  ret_pop_load_a: assert property (take && is_ret |=> stack_pop && pc_load
      && pc_load_value == $past(stack_top_value))
    else $error("return did not pop the stack into the counter");
  gie_set_a: assert property (take && is_irq |=> interrupt_control_reg_set && interrupt_control_reg_mask[7])
    else $error("interrupt return did not set the global enable");
  ret_two_cycle_a: assert property (take && is_ret |=> s_flush)
    else $error("return did not take two cycles");
  lit_to_w_a: assert property (take && is_lit |=> w_we && w_data == $past(instr_word[7:0]))
    else $error("literal return wrote the wrong working value");
  ret_no_flags_a: assert property (take && is_ret |=> !carry_we && !file_we)
    else $error("return touched the carry or a file register");
  rot_left_a: assert property (take && is_rl |=> carry_we && carry_data == $past(file_rd_data[7])
      && dst == $past(rl_res))
    else $error("left rotate result or carry wrong");
  rot_right_a: assert property (take && is_rr |=> carry_we && carry_data == $past(file_rd_data[0])
      && dst == $past(rr_res))
    else $error("right rotate result or carry wrong");
  rot_dest_a: assert property (take && (is_rl || is_rr) |=> file_we == $past(instr_word[9])
      && w_we != file_we && (!file_we || file_wr_addr == $past(file_rd_addr)))
    else $error("rotate result went to the wrong place");
  flush_cause_a: assert property (fetch_flush |-> $past(take && is_ret))
    else $error("fetch flushed without a return");
endmodule : rre_exec_sva

bind rre_exec rre_exec_sva rre_exec_sva_i (.*);

// ===== sim/rre_core_model.sv
// Purpose: Behavioural core around the execute stage: file, carry, stack.
// Assumes: Pulses are applied at the edge that ends their cycle.
// Notes:   The bench preloads memory, carry and stack through hierarchy.
`timescale 1ns/100ps
`include "rre_cfg.svh"

module rre_core_model (
  input  wire logic                     core_clk,
  input  wire logic [`RRE_FADDR_W-1:0]  file_rd_addr,
  output logic      [`RRE_DATA_W-1:0]   file_rd_data,
  input  wire logic                     file_we,
  input  wire logic [`RRE_FADDR_W-1:0]  file_wr_addr,
  input  wire logic [`RRE_DATA_W-1:0]   file_wr_data,
  output logic                          carry_in,
  input  wire logic                     carry_we,
  input  wire logic                     carry_data,
  output logic      [`RRE_PC_W-1:0]     stack_top_value,
  input  wire logic                     stack_pop
);
  logic [7:0]  mem [0:127];
  logic [14:0] stk [0:7];
  logic [2:0]  sp;
  logic        carry;

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    foreach (stk[i]) stk[i] = 15'h0000;
    sp = 3'h0;
    carry = 1'b0;
  end

  assign file_rd_data    = mem[file_rd_addr];
  assign carry_in        = carry;
  assign stack_top_value = stk[sp];

  always @(posedge core_clk) begin
    if (file_we) mem[file_wr_addr] <= file_wr_data;
    if (carry_we) carry <= carry_data;
    if (stack_pop) sp <= sp - 3'h1;
  end
endmodule : rre_core_model

// ===== sim/rre_exec_tb_top.sv
// Purpose: Self-checking bench for the return and rotate execute stage.
// Assumes: Words offered at the falling edge; effects read one cycle later.
// Notes:   Each scenario checks its own results before returning.
`timescale 1ns/100ps
`include "rre_cfg.svh"

module rre_exec_tb_top;
  logic core_clk, rst_b, instr_valid, instr_ready, stack_pop, pc_load, fetch_flush, w_we, file_we;
  logic carry_in, carry_we, carry_data, interrupt_control_reg_set;
  logic [`RRE_INSTR_W-1:0] instr_word;
  logic [`RRE_PC_W-1:0]    stack_top_value, pc_load_value;
  logic [`RRE_DATA_W-1:0]  w_data, file_rd_data, file_wr_data, interrupt_control_reg_mask;
  logic [`RRE_FADDR_W-1:0] file_rd_addr, file_wr_addr;
  int error_cnt = 0;
  int n_compared = 0;

  rre_exec       rre_exec_i (.*);
  rre_core_model rre_core_model_i (.*);

  always #2 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Leaves the bench in the cycle after the taking edge, where pulses stand.
  task automatic issue(input logic [15:0] w);
    @(negedge core_clk);
    instr_valid = 1'b1;
    instr_word  = w;
    @(negedge core_clk);
    instr_valid = 1'b0;
  endtask : issue

  task automatic t_returns();
    logic [15:0] w [7] = '{16'h0012, 16'h0013, 16'h0010, 16'h0011, 16'h0C00, 16'h0CFF, 16'h0C5A};
    logic [14:0] v;
    for (int i = 0; i < 7; i++) begin
      v = 15'h4A30 ^ 15'(i);
      rre_core_model_i.sp = 3'h2;
      rre_core_model_i.stk[2] = v;
      issue(w[i]);
      chk("pc_load_value", v, pc_load_value);
      chk("pop_load_flush", 3'h7, {stack_pop, pc_load, fetch_flush});
      chk("ready_flush", 1'b0, instr_ready);
      chk("gie_set", w[i][15:1] == 15'h0008, interrupt_control_reg_set);
      chk("gie_mask", 8'h80, interrupt_control_reg_mask);
      chk("w_we", w[i][11], w_we);
      if (w[i][11]) chk("w_data", w[i][7:0], w_data);
      chk("flags", 2'h0, {carry_we, file_we});
      @(negedge core_clk);
      chk("sp", 3'h1, rre_core_model_i.sp);
      chk("ready_again", 5'h01, {stack_pop, pc_load, fetch_flush, w_we, instr_ready});
    end
  endtask : t_returns

  task automatic t_rotates();
    logic [15:0] w [5] = '{16'h3405, 16'h367F, 16'h3000, 16'h3221, 16'h0000};
    logic [7:0]  f [5] = '{8'hE6, 8'h81, 8'h01, 8'h7E, 8'h00};
    logic        c [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0]  r;
    logic        co;
    for (int i = 0; i < 5; i++) begin
      @(negedge core_clk);
      rre_core_model_i.mem[w[i][6:0]] = f[i];
      rre_core_model_i.carry = c[i];
      r  = w[i][10] ? {f[i][6:0], c[i]} : {c[i], f[i][7:1]};
      co = w[i][10] ? f[i][7] : f[i][0];
      issue(w[i]);
      chk("file_rd_addr", w[i][6:0], file_rd_addr);
      if (w[i][13]) begin
        chk("carry_data", co, carry_data);
        chk("dest", {1'b1, w[i][9], !w[i][9]}, {carry_we, file_we, w_we});
        chk("result", r, w[i][9] ? file_wr_data : w_data);
        if (w[i][9]) chk("file_wr_addr", w[i][6:0], file_wr_addr);
      end else begin
        chk("idle", 4'h0, {carry_we, file_we, w_we, stack_pop});
      end
    end
  endtask : t_rotates

  task automatic report_and_stop();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk    = 1'b0;
    rst_b       = 1'b0;
    instr_valid = 1'b0;
    instr_word  = 16'h0000;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    t_returns();
    t_rotates();
    report_and_stop();
  end

  // The tests need about 40 cycles; over twelve times that is a hang.
  initial begin
    #2000;
    error_cnt++;
    report_and_stop();
  end
endmodule : rre_exec_tb_top
